/* File: verilog/acc_top.sv */
/*
  Analog comparator control wrapper with AXI4-Lite register slave.
  Assumes the analog core result is asynchronous to mclk and that
  the core's power, hysteresis and pull-up controls are level inputs.
*/
// Function
// - Enable bit 6 powers comparator on
// - Clearing enable forces output bit low
// - Polarity bit 5 inverts result
// - Bit 4 reads polarity-adjusted comparison
// - Bit 0 hysteresis, resets to one
// - Bits 7,3..1 read zero, ignore writes
// - Output change sets flag, raises interrupt
// - Flag rising wakes core from sleep
// - Comparator keeps running during sleep
// - Input pin selection drops pull-up
// - Output routable onto shared pin
`timescale 1ns/1ps
module acc_top
#(
  parameter int ADDR_W = 12
)
(
  input wire logic mclk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog core side
  input wire logic cmpRaw,
  output logic cmpPowerOn,
  output logic cmpHysteresisOn,
  // Core power state and wake
  input wire logic coreSleep,
  output logic wakeUp,
  // Pin sharing
  output logic pullUpInpDisable,
  output logic pullUpInnDisable,
  output logic cmpPinOut,
  output logic cmpPinOutEn,
  // Interrupt request
  output logic irq
);
  import acc_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Declarations
  acc_byte_t ctrl_reg; // Writable control bits
  acc_byte_t ctrl_next;
  logic res_reg; // Polarity-adjusted result bit
  logic res_next;
  logic [`ACC_EV_W-1:0] mask_reg; // Interrupt mask
  logic [`ACC_EV_W-1:0] mask_next;
  logic [`ACC_PINSEL_W-1:0] pinsel_reg; // Shared pin function select
  logic [`ACC_PINSEL_W-1:0] pinsel_next;
  acc_wstate_t wstate_reg;
  acc_wstate_t wstate_next;
  acc_rstate_t rstate_reg;
  acc_rstate_t rstate_next;
  logic [ADDR_W-1:0] awaddr_reg; // Captured write address
  logic [ADDR_W-1:0] awaddr_next;
  logic awHave_reg; // Address held, waiting for data
  logic awHave_next;
  logic [31:0] wdata_reg; // Captured write data
  logic [31:0] wdata_next;
  logic [3:0] wstrb_reg;
  logic [3:0] wstrb_next;
  logic wHave_reg; // Data held, waiting for address
  logic wHave_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  logic cmpSync; // Raw result in mclk domain
  logic resNew; // Result as it would now read
  logic resChange; // One-cycle change event
  logic doWrite; // Write commits this cycle
  logic doRead; // Read address taken this cycle
  logic statRead; // Read of status clears it
  logic [`ACC_EV_W-1:0] statSet; // Software preset of flag
  logic [`ACC_EV_W-1:0] status;

  ////////////////////////////////////////////////////////////////
  // Address decode shared by reads and writes
  function automatic logic isReg(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    isReg = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = isReg(a, `ACC_CTRL_OFS) || isReg(a, `ACC_STAT_OFS)
      || isReg(a, `ACC_MASK_OFS) || isReg(a, `ACC_PINSEL_OFS);
  endfunction

  ////////////////////////////////////////////////////////////////
  // Synchroniser for the analog result
  acc_sync #(
    .WIDTH(1)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .asyncIn(cmpRaw),
    .syncOut(cmpSync)
  );

  // Result forms from synchronised core output, forced low when off
  always_comb
  begin
    resNew = 1'b0;
    if (ctrl_reg[`ACC_ON_BIT])
      resNew = cmpSync ^ ctrl_reg[`ACC_INV_BIT];
    res_next = resNew;
  end

  // Any change of the result bit is an event
  assign resChange = (resNew != res_reg);

  ////////////////////////////////////////////////////////////////
  // Event status and interrupt
  assign statRead = doRead && isReg(s_axi_araddr, `ACC_STAT_OFS);
  assign statSet = (doWrite && isReg(awaddr_next, `ACC_STAT_OFS) && wstrb_next[0])
    ? wdata_next[`ACC_EV_W-1:0] : '0;

  acc_event #(
    .WIDTH(`ACC_EV_W)
  ) u_event (
    .mclk(mclk),
    .rst_n(rst_n),
    .evPulse(resChange),
    .setSw(statSet),
    .readClear(statRead),
    .mask(mask_reg),
    .status(status),
    .irq(irq)
  );

  // Wake on the flag rising in sleep; a preset flag gives no new edge
  logic flagPrev_reg; // Flag as it stood one cycle ago, registered below
  logic flagPrev_next;
  assign flagPrev_next = status[`ACC_EV_CHANGE];

  // Wake only on a fresh flag rising while asleep
  assign wakeUp = coreSleep && status[`ACC_EV_CHANGE] && !flagPrev_reg;

  ////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  always_comb
  begin
    wstate_next = wstate_reg;
    awaddr_next = awaddr_reg;
    awHave_next = awHave_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    wHave_next = wHave_reg;
    bresp_next = bresp_reg;
    doWrite = 1'b0;
    case (wstate_reg)
      ACC_W_IDLE:
      begin
        // Capture each half as it arrives
        if (s_axi_awvalid && !awHave_reg)
        begin
          awaddr_next = s_axi_awaddr;
          awHave_next = 1'b1;
        end
        if (s_axi_wvalid && !wHave_reg)
        begin
          wdata_next = s_axi_wdata;
          wstrb_next = s_axi_wstrb;
          wHave_next = 1'b1;
        end
        // Commit when both halves present
        if (awHave_next && wHave_next)
        begin
          doWrite = 1'b1;
          awHave_next = 1'b0;
          wHave_next = 1'b0;
          bresp_next = isMapped(awaddr_next) ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
          wstate_next = ACC_W_RESP;
        end
      end
      ACC_W_RESP:
      begin
        // Hold response until accepted
        if (s_axi_bready)
          wstate_next = ACC_W_IDLE;
      end
      default:
        wstate_next = ACC_W_IDLE;
    endcase
  end

  assign s_axi_awready = (wstate_reg == ACC_W_IDLE) && !awHave_reg;
  assign s_axi_wready = (wstate_reg == ACC_W_IDLE) && !wHave_reg;
  assign s_axi_bvalid = (wstate_reg == ACC_W_RESP);
  assign s_axi_bresp = bresp_reg;

  ////////////////////////////////////////////////////////////////
  // Register writes; only implemented bits take effect
  always_comb
  begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    pinsel_next = pinsel_reg;
    if (doWrite && wstrb_next[0])
    begin
      if (isReg(awaddr_next, `ACC_CTRL_OFS))
        ctrl_next = wdata_next[7:0] & `ACC_CTRL_WMASK;
      if (isReg(awaddr_next, `ACC_MASK_OFS))
        mask_next = wdata_next[`ACC_EV_W-1:0];
      if (isReg(awaddr_next, `ACC_PINSEL_OFS))
        pinsel_next = wdata_next[`ACC_PINSEL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read channel: one cycle from address to data
  always_comb
  begin
    rstate_next = rstate_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    doRead = 1'b0;
    case (rstate_reg)
      ACC_R_IDLE:
      begin
        if (s_axi_arvalid)
        begin
          doRead = 1'b1;
          rresp_next = isMapped(s_axi_araddr) ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
          rdata_next = '0;
          if (isReg(s_axi_araddr, `ACC_CTRL_OFS))
          begin
            // Result bit merged in; unimplemented bits read zero
            rdata_next[7:0] = ctrl_reg;
            rdata_next[`ACC_RES_BIT] = res_reg;
          end
          if (isReg(s_axi_araddr, `ACC_STAT_OFS))
            rdata_next[`ACC_EV_W-1:0] = status;
          if (isReg(s_axi_araddr, `ACC_MASK_OFS))
            rdata_next[`ACC_EV_W-1:0] = mask_reg;
          if (isReg(s_axi_araddr, `ACC_PINSEL_OFS))
            rdata_next[`ACC_PINSEL_W-1:0] = pinsel_reg;
          rstate_next = ACC_R_DATA;
        end
      end
      ACC_R_DATA:
      begin
        if (s_axi_rready)
          rstate_next = ACC_R_IDLE;
      end
      default:
        rstate_next = ACC_R_IDLE;
    endcase
  end

  assign s_axi_arready = (rstate_reg == ACC_R_IDLE);
  assign s_axi_rvalid = (rstate_reg == ACC_R_DATA);
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  ////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= `ACC_CTRL_RST;
      res_reg <= 1'b0;
      mask_reg <= '0;
      pinsel_reg <= '0;
      wstate_reg <= ACC_W_IDLE;
      rstate_reg <= ACC_R_IDLE;
      awaddr_reg <= '0;
      awHave_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      wHave_reg <= 1'b0;
      bresp_reg <= `ACC_RESP_OKAY;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `ACC_RESP_OKAY;
      flagPrev_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      res_reg <= res_next;
      mask_reg <= mask_next;
      pinsel_reg <= pinsel_next;
      wstate_reg <= wstate_next;
      rstate_reg <= rstate_next;
      awaddr_reg <= awaddr_next;
      awHave_reg <= awHave_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      wHave_reg <= wHave_next;
      bresp_reg <= bresp_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      flagPrev_reg <= flagPrev_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Analog and pin controls, all from flops
  assign cmpPowerOn = ctrl_reg[`ACC_ON_BIT];
  assign cmpHysteresisOn = ctrl_reg[`ACC_HYS_BIT];
  assign pullUpInpDisable = pinsel_reg[`ACC_PS_INP];
  assign pullUpInnDisable = pinsel_reg[`ACC_PS_INN];
  assign cmpPinOut = res_reg;
  assign cmpPinOutEn = pinsel_reg[`ACC_PS_OUT];
endmodule

/* File: verilog/acc_map.svh */
/*
  Register offsets, field positions, reset values and widths for the
  comparator control block.
  Assumes it is included by bare name from the package and modules.
*/
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// Byte offsets on the register bus
`define ACC_CTRL_OFS 12'h000
`define ACC_STAT_OFS 12'h004
`define ACC_MASK_OFS 12'h008
`define ACC_PINSEL_OFS 12'h00C

// Control register field positions
`define ACC_ON_BIT 6
`define ACC_INV_BIT 5
`define ACC_RES_BIT 4
`define ACC_HYS_BIT 0

// Control register reset value: only hysteresis set
`define ACC_CTRL_RST 8'h01
// Writable bits of the control register
`define ACC_CTRL_WMASK 8'h61

// Status and mask layout: bit 0 result changed
`define ACC_EV_CHANGE 0
`define ACC_EV_W 1

// Pin select fields
`define ACC_PS_INP 0
`define ACC_PS_INN 1
`define ACC_PS_OUT 2
`define ACC_PINSEL_W 3

// Bus response codes
`define ACC_RESP_OKAY 2'h0
`define ACC_RESP_SLVERR 2'h2

`endif

/* File: verilog/acc_pkg.sv */
/*
  Types for the comparator control block.
  Assumes acc_map.svh is on the include path.
*/
package acc_pkg;
  `include "acc_map.svh"

  // Write channel states of the bus slave
  typedef enum logic [1:0]
  {
    ACC_W_IDLE = 2'b00,
    ACC_W_RESP = 2'b01
  } acc_wstate_t;

  // Read channel states of the bus slave
  typedef enum logic [1:0]
  {
    ACC_R_IDLE = 2'b00,
    ACC_R_DATA = 2'b01
  } acc_rstate_t;

  typedef logic [7:0] acc_byte_t;
endpackage

/* File: verilog/acc_sync.sv */
/*
  Two-flop synchroniser for an asynchronous level.
  Assumes the input comes from the analog domain or a pin.
*/
`timescale 1ns/1ps
module acc_sync
  import acc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  ////////////////////////////////////////////////////////////////
  // Next values: first flop only feeds second
  always_comb
  begin
    meta_next = asyncIn;
    sync_next = meta_reg;
  end

  // Registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign syncOut = sync_reg;
endmodule

/* File: verilog/acc_event.sv */
/*
  Sticky event status with mask and read-to-clear.
  Assumes one-cycle event pulses and one-cycle read strobe on mclk.
*/
`timescale 1ns/1ps
module acc_event
  import acc_pkg::*;
#(
  parameter int WIDTH = `ACC_EV_W
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] evPulse,
  input wire logic [WIDTH-1:0] setSw,
  input wire logic readClear,
  input wire logic [WIDTH-1:0] mask,
  output logic [WIDTH-1:0] status,
  output logic irq
);
  import acc_pkg::*;

  logic [WIDTH-1:0] stat_reg;
  logic [WIDTH-1:0] stat_next;

  ////////////////////////////////////////////////////////////////
  // Set wins over a read clear so no event is lost
  always_comb
  begin
    stat_next = stat_reg;
    if (readClear)
    begin
      stat_next = '0;
    end
    stat_next = stat_next | evPulse | setSw;
  end

  // Status register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_reg <= '0;
    end
    else
    begin
      stat_reg <= stat_next;
    end
  end

  assign status = stat_reg;
  // Level interrupt while any unmasked bit is set
  assign irq = |(stat_reg & mask);
endmodule

/* File: sim/acc_cmp_model.sv */
/* Behavioural analog comparator core with two input levels.
   Assumes levels are set by the bench and power comes from the block. */
`timescale 1ns/1ps
module acc_cmp_model
#(
  parameter int HYS = 10
)
(
  input wire logic mclk,
  input wire logic cmpPowerOn,
  input wire logic cmpHysteresisOn,
  input wire logic [7:0] vPos,
  input wire logic [7:0] vNeg,
  output logic cmpRaw
);
  ////////////////////////////////////////////////////////////////
  // Powered off the result means nothing, so it wanders; on the falling
  // edge so a power-up at the rising edge cannot race the compare below
  always @(negedge mclk)
  begin
    if (!cmpPowerOn)
      cmpRaw = ~cmpRaw;
  end
  // Powered on: compare, ignoring sleep, with a dead band
  always @(vPos, vNeg, cmpPowerOn, cmpHysteresisOn)
  begin
    if (cmpPowerOn && (vPos > vNeg + (cmpHysteresisOn ? HYS : 0)))
      cmpRaw = 1'h1;
    else if (cmpPowerOn && (vNeg > vPos + (cmpHysteresisOn ? HYS : 0)))
      cmpRaw = 1'h0;
  end
  initial cmpRaw = 1'h0;
endmodule

/* File: sim/acc_top_asserts.sv */
/* Port checker for the comparator control block.
   Assumes it is bound to acc_top from the bench top file. */
`timescale 1ns/1ps
module acc_top_chk
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic cmpRaw,
  input wire logic cmpPowerOn,
  input wire logic cmpHysteresisOn,
  input wire logic coreSleep,
  input wire logic wakeUp,
  input wire logic pullUpInpDisable,
  input wire logic cmpPinOut,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  off_forces_low_a: assert property ((!cmpPowerOn)[*3] |-> !cmpPinOut)
    else $error("result high while off");
  // Sync plus result stages: a change must trace to the raw input
  pin_follows_raw_a: assert property (cmpPowerOn && $past(cmpPowerOn, 3) && $changed(cmpPinOut)
    && !$past(s_axi_wvalid) && !$past(s_axi_wvalid, 2) && !$past(s_axi_wvalid, 3)
    |-> $past(cmpRaw, 3) != $past(cmpRaw, 4) || $past(cmpRaw, 4) != $past(cmpRaw, 5))
    else $error("result moved without input change");
  wake_in_sleep_a: assert property (wakeUp |-> coreSleep)
    else $error("wake while awake");
  wake_single_a: assert property (wakeUp |=> !wakeUp)
    else $error("wake longer than a cycle");
  hyst_by_write_a: assert property ($changed(cmpHysteresisOn) |-> $past(s_axi_wvalid))
    else $error("hysteresis moved without write");
  power_by_write_a: assert property ($changed(cmpPowerOn) |-> $past(s_axi_wvalid))
    else $error("power moved without write");
  pullup_by_write_a: assert property ($changed(pullUpInpDisable) |-> $past(s_axi_wvalid))
    else $error("pull-up moved without write");
  irq_falls_a: assert property ($fell(irq) |-> $past(s_axi_arvalid) || $past(s_axi_wvalid))
    else $error("irq dropped without access");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wake_c: cover property (wakeUp);
  irq_c: cover property ($rose(irq));
  slverr_c: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

/* File: sim/tb_analog_comparator_control.sv */
/* Self-checking bench for the comparator control block.
   Assumes acc_top, its package and the core model are compiled first. */
`timescale 1ns/1ps
module tb_analog_comparator_control;
  import acc_pkg::*;
  logic mclk, rst_n, coreSleep, cmpRaw, cmpPowerOn, cmpHysteresisOn, wakeUp, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic pullUpInpDisable, pullUpInnDisable, cmpPinOut, cmpPinOutEn, exp;
  logic [7:0] vPos, vNeg;
  int n_errors = 0;
  int n_compared = 0;
  int wakeCnt = 0;
  ////////////////////////////////////////////////////////////////
  acc_top acc_top_inst (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmpRaw, .cmpPowerOn, .cmpHysteresisOn, .coreSleep, .wakeUp,
    .pullUpInpDisable, .pullUpInnDisable, .cmpPinOut, .cmpPinOutEn, .irq);
  acc_cmp_model acc_cmp_model_inst (.mclk, .cmpPowerOn, .cmpHysteresisOn, .vPos, .vNeg, .cmpRaw);
  initial
  begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end
  // Wake pulses are counted in the background
  always @(posedge mclk)
  begin
    if (wakeUp === 1'h1)
      wakeCnt++;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, want, seen);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic awGot, wGot;
    awGot = 1'h0;
    wGot = 1'h0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(awGot && wGot))
    begin
      @(posedge mclk);
      awGot = awGot | (s_axi_awvalid & s_axi_awready);
      wGot = wGot | (s_axi_wvalid & s_axi_wready);
      s_axi_awvalid <= !awGot;
      s_axi_wvalid <= !wGot;
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rdReg(input logic [11:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge mclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // Six edges cover the core, the synchroniser and the result stage
  task automatic setV(input logic [7:0] p, input logic [7:0] n);
    @(posedge mclk);
    vPos <= p;
    vNeg <= n;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic tReset;
    rdReg(12'h000);
    check("ctrl reset", rd, 32'h01);
    check("hyst pin", cmpHysteresisOn, 1'h1);
    check("power pin", cmpPowerOn, 1'h0);
  endtask
  task automatic tBits;
    setV(8'h10, 8'h80);
    wr(12'h000, 8'hFF);
    repeat (6) @(posedge mclk);
    rdReg(12'h000);
    check("ctrl ones", rd, 32'h71);
    wr(12'h000, 8'h00);
    repeat (4) @(posedge mclk);
    rdReg(12'h000);
    check("ctrl zeros", rd, 32'h00);
    check("hyst off", cmpHysteresisOn, 1'h0);
    rdReg(12'h004);
    check("off flag", rd, 32'h01);
  endtask
  // Both polarities, both input senses, then a flip of the inputs
  task automatic tPolarity;
    wr(12'h008, 8'h01);
    wr(12'h00C, 8'h04);
    for (int i = 0; i < 4; i++)
    begin
      wr(12'h000, {1'h0, 1'h1, i[1], 5'h01});
      setV(i[0] ? 8'h80 : 8'h10, 8'h40);
      rdReg(12'h004);
      exp = i[0] ^ i[1];
      rdReg(12'h000);
      check("result bit", rd[4], exp);
      check("pin out", cmpPinOut, exp);
      @(posedge mclk);
      vPos <= i[0] ? 8'h10 : 8'h80;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      check("sync delay", cmpPinOut, exp);
      repeat (4) @(negedge mclk);
      check("new result", cmpPinOut, !exp);
      check("irq up", irq, 1'h1);
      rdReg(12'h004);
      check("flag", rd, 32'h01);
      @(negedge mclk);
      check("irq clear", irq, 1'h0);
    end
  endtask
  task automatic tMaskSleep;
    wr(12'h008, 8'h00);
    coreSleep <= 1'h1;
    wakeCnt = 0;
    setV(8'h80, 8'h40);
    check("irq masked", irq, 1'h0);
    check("wake once", wakeCnt, 1);
    rdReg(12'h004);
    check("masked flag", rd, 32'h01);
    // Software presets the flag while awake, then the core sleeps again
    coreSleep <= 1'h0;
    wr(12'h004, 8'h01);
    coreSleep <= 1'h1;
    wakeCnt = 0;
    setV(8'h10, 8'h40);
    check("wake blocked", wakeCnt, 0);
    wr(12'h000, 8'h01);
    rdReg(12'h004);
    wakeCnt = 0;
    setV(8'h80, 8'h40);
    check("off no wake", wakeCnt, 0);
    check("off low", cmpPinOut, 1'h0);
    coreSleep <= 1'h0;
  endtask
  task automatic tPins;
    wr(12'h00C, 8'h03);
    @(negedge mclk);
    check("pull inp", pullUpInpDisable, 1'h1);
    check("pull inn", pullUpInnDisable, 1'h1);
    check("pin en off", cmpPinOutEn, 1'h0);
    wr(12'h00C, 8'h04);
    @(negedge mclk);
    check("pull back", {pullUpInpDisable, pullUpInnDisable, cmpPinOutEn}, 3'h1);
  endtask
  task automatic tUnmapped;
    wr(12'h010, 8'hFF);
    check("wr slverr", rsp, 2'h2);
    rdReg(12'h010);
    check("rd slverr", rsp, 2'h2);
    check("rd zero", rd, 32'h0);
  endtask
  task automatic summarize;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_n, coreSleep, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    vPos = 8'h00;
    vNeg = 8'h40;
    repeat (8) @(posedge mclk);
    rst_n <= 1'h1;
    tReset;
    tBits;
    tPolarity;
    tMaskSleep;
    tPins;
    tUnmapped;
    summarize;
  end
  // Twenty thousand cycles is ample for this sequence
  initial
  begin
    #(20000 * 25);
    n_errors++;
    summarize;
  end
endmodule
bind acc_top acc_top_chk acc_top_chk_inst (.mclk, .rst_n, .s_axi_wvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .cmpRaw, .cmpPowerOn, .cmpHysteresisOn,
  .coreSleep, .wakeUp, .pullUpInpDisable, .cmpPinOut, .irq);
